// ---- src/sst_pkg.sv ----
// Constants and types shared by the self-test result status bank.
package sst_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 24;
  localparam int SAMPLE_W = 10;
  localparam logic [ADDR_W-1:0] VDS_RESULT_OFFSET = 6'h15;
  localparam logic [ADDR_W-1:0] STUCKON_RESULT_OFFSET = 6'h16;
  localparam logic [ADDR_W-1:0] CURRENT_RESULT_OFFSET = 6'h17;
  localparam logic [ADDR_W-1:0] FAST_CURRENT_OFFSET = 6'h18;
  localparam int PARITY_POS = 0;
  localparam int STATE_POS = 1;
  localparam int RESULT_POS = 3;
  localparam int FLAG_LOW_POS = 13;
  localparam int FLAG_HIGH_POS = 14;
  localparam int FAST_FRESH_POS = 1;
  localparam int FAST_SAMPLE_POS = 2;
  localparam logic [SAMPLE_W-1:0] SAMPLE_RESET = 10'h000;
  localparam logic [DATA_W-1:0] WORD_RESET = 24'h000000;
  // Declaration order gives 00 idle, 01 running, 10 completed, 11 aborted.
  typedef enum logic [1:0] {
    TEST_IDLE,
    TEST_RUN,
    TEST_END,
    TEST_ABORT
  } sst_state_type;
endpackage

// ---- src/sst_test_tracker.sv ----
// One self-test result tracker: state code, two limit flags and a result value.
`timescale 1ns/100ps
`default_nettype none
module sst_test_tracker #(
  parameter bit SUBTRACT = 1'b1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic start,
  input wire logic finish,
  input wire logic abort_req,
  input wire logic sample_valid,
  input wire logic [sst_pkg::SAMPLE_W-1:0] sample_value,
  input wire logic [sst_pkg::SAMPLE_W-1:0] reference_value,
  input wire logic [1:0] limit_hit,
  input wire logic host_clear,
  output logic [1:0] state_code,
  output logic [1:0] limit_flags,
  output logic [sst_pkg::SAMPLE_W-1:0] result_value,
  output logic result_stored,
  output logic running
);
  import sst_pkg::*;

  sst_state_type state_reg;
  logic captured_reg;
  logic finish_seen_reg;
  logic [1:0] flags_reg;
  logic [SAMPLE_W-1:0] value_reg;
  logic store;

  assign running = (state_reg == TEST_RUN);
  assign store = running && sample_valid && !abort_req;
  assign result_stored = store;
  assign state_code = state_reg;
  assign limit_flags = flags_reg;
  assign result_value = value_reg;

  // Test state; abort wins over completion, completion waits for a stored result.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= TEST_IDLE;
    end else begin
      case (state_reg)
        TEST_IDLE: begin
          if (start) begin
            state_reg <= TEST_RUN;
          end
        end
        TEST_RUN: begin
          if (abort_req) begin
            state_reg <= TEST_ABORT;
          end else if ((finish || finish_seen_reg) && (captured_reg || sample_valid)) begin
            state_reg <= TEST_END;
          end
        end
        TEST_END, TEST_ABORT: begin
          if (start) begin
            state_reg <= TEST_RUN;
          end else if (host_clear) begin
            state_reg <= TEST_IDLE;
          end
        end
        default: begin
          state_reg <= TEST_IDLE;
        end
      endcase
    end
  end

  // Remembers a finish that came before the result so completion is deferred.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      finish_seen_reg <= 1'b0;
      captured_reg <= 1'b0;
    end else if (!running) begin
      finish_seen_reg <= 1'b0;
      captured_reg <= 1'b0;
    end else begin
      finish_seen_reg <= finish_seen_reg || finish;
      captured_reg <= captured_reg || store;
    end
  end

  // Limit flags are set during the test; a set in the clear cycle wins.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      flags_reg <= 2'b00;
    end else if (start && !running) begin
      flags_reg <= 2'b00;
    end else begin
      flags_reg <= (host_clear ? 2'b00 : flags_reg) | (running ? limit_hit : 2'b00);
    end
  end

  // Result is the sample or its difference to the value latched before the test.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      value_reg <= SAMPLE_RESET;
    end else if (store) begin
      value_reg <= SUBTRACT ? SAMPLE_W'(sample_value - reference_value) : sample_value;
    end else if (host_clear && !running) begin
      value_reg <= SAMPLE_RESET;
    end
  end
endmodule // sst_test_tracker
`default_nettype wire

// ---- src/sst_status_bank.sv ----
// Self-test result status bank with the fast current-sense sample.
`timescale 1ns/100ps
`default_nettype none
// Operation
// - Drain-source test state is a two-bit code: idle, running, completed, aborted.
// - Stuck-on test state uses its own two-bit field with the same codes.
// - Current-sense test state uses a further two-bit field, same codes.
// - Watchdog timeout, lockout input or unneeded stop request aborts a running test.
// - Completed code appears only once result values are stored and valid.
// - Bit 13 of drain-source register flags drain-source limit reached during test.
// - Bits 12 to 3 hold drain-source conversion minus pre-test latched value.
// - Bit 13 of stuck-on register flags drain-source limit reached during test.
// - Bits 12 to 3 of stuck-on register hold the test conversion.
// - Update flags set on refresh, cleared on host read; stuck-on bit 14, fast bit 1.
// - Bit 14 of current-sense register flags hard-short limit during test.
// - Bit 13 of current-sense register flags overcurrent limit during test.
// - Bits 12 to 3 hold current conversion minus pre-test fast sample.
// - Fast current register holds 10-bit shunt sample in bits 11 to 2.
// - Fast current sample is frozen while the current-sense test runs.
// - Bit 0 of every register is odd parity over the register contents.
// - Drain-source conversion register is frozen while the drain-source test runs.
module sst_status_bank (
  input wire logic clk,
  input wire logic reset,
  input wire logic rd_en,
  input wire logic [sst_pkg::ADDR_W-1:0] rd_addr,
  input wire logic clr_en,
  input wire logic [sst_pkg::ADDR_W-1:0] clr_addr,
  output logic [sst_pkg::DATA_W-1:0] rd_data,
  output logic rd_valid,
  input wire logic watchdog_timeout,
  input wire logic hardware_lockout,
  input wire logic stop_unneeded,
  input wire logic vds_conv_valid,
  input wire logic [sst_pkg::SAMPLE_W-1:0] vds_conv_data,
  input wire logic fast_conv_valid,
  input wire logic [sst_pkg::SAMPLE_W-1:0] fast_conv_data,
  input wire logic vds_test_start,
  input wire logic vds_test_finish,
  input wire logic vds_test_sample_valid,
  input wire logic [sst_pkg::SAMPLE_W-1:0] vds_test_sample,
  input wire logic vds_test_limit_hit,
  input wire logic stuckon_test_start,
  input wire logic stuckon_test_finish,
  input wire logic stuckon_test_sample_valid,
  input wire logic [sst_pkg::SAMPLE_W-1:0] stuckon_test_sample,
  input wire logic stuckon_test_limit_hit,
  input wire logic csense_test_start,
  input wire logic csense_test_finish,
  input wire logic csense_test_sample_valid,
  input wire logic [sst_pkg::SAMPLE_W-1:0] csense_test_sample,
  input wire logic csense_test_short_hit,
  input wire logic csense_test_overcurrent_hit,
  output logic [sst_pkg::SAMPLE_W-1:0] vds_live_value,
  output logic vds_test_running,
  output logic stuckon_test_running,
  output logic csense_test_running
);
  import sst_pkg::*;

  logic abort_any;
  logic [SAMPLE_W-1:0] vds_latch_reg;
  logic [SAMPLE_W-1:0] fast_current_sample_reg;
  logic fast_current_fresh_reg;
  logic stuckon_result_fresh_reg;
  logic [1:0] vds_test_state;
  logic [1:0] stuckon_test_state;
  logic [1:0] csense_test_state;
  logic [1:0] vds_flags;
  logic [1:0] stuckon_flags;
  logic [1:0] csense_flags;
  logic [SAMPLE_W-1:0] vds_test_delta;
  logic [SAMPLE_W-1:0] stuckon_sample;
  logic [SAMPLE_W-1:0] csense_test_delta;
  logic stuckon_stored;
  logic vds_clear;
  logic stuckon_clear;
  logic csense_clear;
  logic rd_stuckon;
  logic rd_fast;
  logic [DATA_W-1:0] vds_word;
  logic [DATA_W-1:0] stuckon_word;
  logic [DATA_W-1:0] current_word;
  logic [DATA_W-1:0] fast_word;
  logic [DATA_W-1:0] read_word;

  // Odd parity: bit 0 makes the total count of ones over all 24 bits odd.
  function automatic logic [DATA_W-1:0] with_parity(input logic [DATA_W-1:0] word);
    logic [DATA_W-1:0] result;
    result = word;
    result[PARITY_POS] = ~^word[DATA_W-1:PARITY_POS+1];
    return result;
  endfunction

  assign abort_any = watchdog_timeout | hardware_lockout | stop_unneeded;
  assign vds_clear = clr_en && (clr_addr == VDS_RESULT_OFFSET);
  assign stuckon_clear = clr_en && (clr_addr == STUCKON_RESULT_OFFSET);
  assign csense_clear = clr_en && (clr_addr == CURRENT_RESULT_OFFSET);
  assign rd_stuckon = rd_en && (rd_addr == STUCKON_RESULT_OFFSET);
  assign rd_fast = rd_en && (rd_addr == FAST_CURRENT_OFFSET);
  assign vds_live_value = vds_latch_reg;

  sst_test_tracker #(
    .SUBTRACT(1'b1)
  ) u_vds_test (
    .clk(clk),
    .reset(reset),
    .start(vds_test_start),
    .finish(vds_test_finish),
    .abort_req(abort_any),
    .sample_valid(vds_test_sample_valid),
    .sample_value(vds_test_sample),
    .reference_value(vds_latch_reg),
    .limit_hit({1'b0, vds_test_limit_hit}),
    .host_clear(vds_clear),
    .state_code(vds_test_state),
    .limit_flags(vds_flags),
    .result_value(vds_test_delta),
    .result_stored(),
    .running(vds_test_running)
  );

  sst_test_tracker #(
    .SUBTRACT(1'b0)
  ) u_stuckon_test (
    .clk(clk),
    .reset(reset),
    .start(stuckon_test_start),
    .finish(stuckon_test_finish),
    .abort_req(abort_any),
    .sample_valid(stuckon_test_sample_valid),
    .sample_value(stuckon_test_sample),
    .reference_value(SAMPLE_RESET),
    .limit_hit({1'b0, stuckon_test_limit_hit}),
    .host_clear(stuckon_clear),
    .state_code(stuckon_test_state),
    .limit_flags(stuckon_flags),
    .result_value(stuckon_sample),
    .result_stored(stuckon_stored),
    .running(stuckon_test_running)
  );

  sst_test_tracker #(
    .SUBTRACT(1'b1)
  ) u_csense_test (
    .clk(clk),
    .reset(reset),
    .start(csense_test_start),
    .finish(csense_test_finish),
    .abort_req(abort_any),
    .sample_valid(csense_test_sample_valid),
    .sample_value(csense_test_sample),
    .reference_value(fast_current_sample_reg),
    .limit_hit({csense_test_short_hit, csense_test_overcurrent_hit}),
    .host_clear(csense_clear),
    .state_code(csense_test_state),
    .limit_flags(csense_flags),
    .result_value(csense_test_delta),
    .result_stored(),
    .running(csense_test_running)
  );

  // Drain-source conversion is held while the drain-source test runs.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      vds_latch_reg <= SAMPLE_RESET;
    end else if (vds_conv_valid && !vds_test_running) begin
      vds_latch_reg <= vds_conv_data;
    end
  end

  // Fast current sample is held while the current-sense test runs.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fast_current_sample_reg <= SAMPLE_RESET;
    end else if (fast_conv_valid && !csense_test_running) begin
      fast_current_sample_reg <= fast_conv_data;
    end
  end

  // Update flags clear on read; a refresh in the read cycle keeps the flag set.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fast_current_fresh_reg <= 1'b0;
      stuckon_result_fresh_reg <= 1'b0;
    end else begin
      fast_current_fresh_reg <= (fast_current_fresh_reg && !rd_fast)
        || (fast_conv_valid && !csense_test_running);
      stuckon_result_fresh_reg <= (stuckon_result_fresh_reg && !rd_stuckon)
        || stuckon_stored;
    end
  end

  // Register images; unused upper bits stay zero and enter the parity.
  always_comb begin
    vds_word = WORD_RESET;
    vds_word[FLAG_LOW_POS] = vds_flags[0];
    vds_word[RESULT_POS +: SAMPLE_W] = vds_test_delta;
    vds_word[STATE_POS +: 2] = vds_test_state;
    stuckon_word = WORD_RESET;
    stuckon_word[FLAG_HIGH_POS] = stuckon_result_fresh_reg;
    stuckon_word[FLAG_LOW_POS] = stuckon_flags[0];
    stuckon_word[RESULT_POS +: SAMPLE_W] = stuckon_sample;
    stuckon_word[STATE_POS +: 2] = stuckon_test_state;
    current_word = WORD_RESET;
    current_word[FLAG_HIGH_POS] = csense_flags[1];
    current_word[FLAG_LOW_POS] = csense_flags[0];
    current_word[RESULT_POS +: SAMPLE_W] = csense_test_delta;
    current_word[STATE_POS +: 2] = csense_test_state;
    fast_word = WORD_RESET;
    fast_word[FAST_SAMPLE_POS +: SAMPLE_W] = fast_current_sample_reg;
    fast_word[FAST_FRESH_POS] = fast_current_fresh_reg;
  end

  // Address decode; an unmapped address reads all zero.
  always_comb begin
    case (rd_addr)
      VDS_RESULT_OFFSET: read_word = with_parity(vds_word);
      STUCKON_RESULT_OFFSET: read_word = with_parity(stuckon_word);
      CURRENT_RESULT_OFFSET: read_word = with_parity(current_word);
      FAST_CURRENT_OFFSET: read_word = with_parity(fast_word);
      default: read_word = WORD_RESET;
    endcase
  end

  // Read data is captured on the read strobe and answered one cycle later.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rd_data <= WORD_RESET;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_en;
      if (rd_en) begin
        rd_data <= read_word;
      end
    end
  end
endmodule // sst_status_bank
`default_nettype wire

// ---- verification/sst_status_bank_chk.sv ----
// Port checker for the self-test result status bank.
`timescale 1ns/100ps
`default_nettype none
module sst_chk (
  input wire logic clk,
  input wire logic reset,
  input wire logic rd_en,
  input wire logic [sst_pkg::ADDR_W-1:0] rd_addr,
  input wire logic [sst_pkg::DATA_W-1:0] rd_data,
  input wire logic rd_valid,
  input wire logic watchdog_timeout,
  input wire logic hardware_lockout,
  input wire logic stop_unneeded,
  input wire logic vds_conv_valid,
  input wire logic [sst_pkg::SAMPLE_W-1:0] vds_conv_data,
  input wire logic vds_test_start,
  input wire logic [sst_pkg::SAMPLE_W-1:0] vds_live_value,
  input wire logic vds_test_running,
  input wire logic stuckon_test_running,
  input wire logic csense_test_running
);
  import sst_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  wire ab = watchdog_timeout | hardware_lockout | stop_unneeded;
  wire [2:0] run = {csense_test_running, stuckon_test_running, vds_test_running};
  wire mapped = rd_addr >= VDS_RESULT_OFFSET && rd_addr <= FAST_CURRENT_OFFSET;
  sequence s_go; vds_test_start && !vds_test_running && !ab; endsequence
  property p_go; s_go |=> vds_test_running; endproperty
  a_go: assert property (p_go) else $error("test not started");
  property p_abort; ab |=> (run & $past(run)) == 3'b000; endproperty
  a_abort: assert property (p_abort) else $error("test not aborted");
  property p_ans; rd_en |=> rd_valid; endproperty
  a_ans: assert property (p_ans) else $error("read not answered");
  property p_par; rd_en && mapped |=> ^rd_data; endproperty
  a_par: assert property (p_par) else $error("parity not odd");
  property p_unm; rd_en && !mapped |=> rd_data == WORD_RESET; endproperty
  a_unm: assert property (p_unm) else $error("unmapped not zero");
  property p_top; rd_en && mapped |=> rd_data[23:15] == 9'h000; endproperty
  a_top: assert property (p_top) else $error("upper bits set");
  property p_frz; vds_test_running |=> $stable(vds_live_value); endproperty
  a_frz: assert property (p_frz) else $error("live value moved");
  property p_load;
    vds_conv_valid && !vds_test_running |=> vds_live_value == $past(vds_conv_data);
  endproperty
  a_load: assert property (p_load) else $error("live value not loaded");
endmodule // sst_chk
bind sst_status_bank sst_chk chk_u (.*);
`default_nettype wire

// ---- verification/sst_host_model.sv ----
// Host model that reads one status word at a time.
`timescale 1ns/100ps
`default_nettype none
module sst_host_model (
  input wire logic clk,
  output logic rd_en,
  output logic [sst_pkg::ADDR_W-1:0] rd_addr,
  input wire logic [sst_pkg::DATA_W-1:0] rd_data,
  input wire logic rd_valid
);
  import sst_pkg::*;
  initial begin
    rd_en = 1'b0;
    rd_addr = 6'h00;
  end
  task automatic read(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d,
                      output logic ok);
    ok = 1'b0;
    @(negedge clk);
    rd_en = 1'b1;
    rd_addr = a;
    @(negedge clk);
    rd_en = 1'b0;
    rd_addr = ~a;
    for (int i = 0; i < 4 && ok == 1'b0; i++) begin
      if (rd_valid === 1'b1) begin
        ok = 1'b1;
        d = rd_data;
      end else begin
        @(negedge clk);
      end
    end
  endtask
endmodule // sst_host_model
`default_nettype wire

// ---- verification/testbench.sv ----
// Self-checking testbench of the self-test result status bank.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import sst_pkg::*;
  logic clk, reset, clr_en, watchdog_timeout, hardware_lockout, stop_unneeded, ok;
  logic vds_conv_valid, fast_conv_valid;
  logic [ADDR_W-1:0] clr_addr;
  logic [SAMPLE_W-1:0] vds_conv_data, fast_conv_data, s, l, f;
  logic [2:0] go, fin, sv;
  logic [1:0] hit [3];
  logic [SAMPLE_W-1:0] smp [3];
  logic [DATA_W-1:0] got;
  logic [15:0] lfsr;
  int num_errors, num_checks;
  wire rd_en, rd_valid, vds_test_running, stuckon_test_running, csense_test_running;
  wire [ADDR_W-1:0] rd_addr;
  wire [DATA_W-1:0] rd_data;
  wire [SAMPLE_W-1:0] vds_live_value;
  sst_status_bank dut_u (.*, .vds_test_start(go[0]), .vds_test_finish(fin[0]),
    .vds_test_sample_valid(sv[0]), .vds_test_sample(smp[0]), .vds_test_limit_hit(hit[0][0]),
    .stuckon_test_start(go[1]), .stuckon_test_finish(fin[1]),
    .stuckon_test_sample_valid(sv[1]), .stuckon_test_sample(smp[1]),
    .stuckon_test_limit_hit(hit[1][0]), .csense_test_start(go[2]),
    .csense_test_finish(fin[2]), .csense_test_sample_valid(sv[2]),
    .csense_test_sample(smp[2]), .csense_test_short_hit(hit[2][1]),
    .csense_test_overcurrent_hit(hit[2][0]));
  sst_host_model host_u (.*);
  function automatic logic [DATA_W-1:0] word(input logic [DATA_W-1:1] b);
    return {b, ~^b};
  endfunction
  function automatic logic [SAMPLE_W-1:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr[SAMPLE_W-1:0];
  endfunction
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [DATA_W-1:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp,
                    input logic [DATA_W-1:0] mask = '1);
    host_u.read(a, got, ok);
    if (ok !== 1'b1) begin
      check("read answer", 24'h000000, 24'h000001);
      end_of_test();
    end
    check("read word", got & mask, exp & mask);
  endtask
  task automatic conv(input logic fast, input logic [SAMPLE_W-1:0] v);
    @(negedge clk);
    fast_conv_valid = fast;
    vds_conv_valid = !fast;
    fast_conv_data = v;
    vds_conv_data = v;
    @(negedge clk);
    {fast_conv_valid, vds_conv_valid} = 2'b00;
  endtask
  task automatic clear(input logic [ADDR_W-1:0] a);
    @(negedge clk);
    clr_en = 1'b1;
    clr_addr = a;
    @(negedge clk);
    clr_en = 1'b0;
  endtask
  task automatic run_t(input int t, input logic [SAMPLE_W-1:0] v, input logic [1:0] h);
    @(negedge clk);
    go[t] = 1'b1;
    @(negedge clk);
    go[t] = 1'b0;
    sv[t] = 1'b1;
    smp[t] = v;
    hit[t] = h;
    vds_conv_valid = (t == 0);
    fast_conv_valid = (t == 2);
    vds_conv_data = ~v;
    fast_conv_data = ~v;
    @(negedge clk);
    {sv[t], vds_conv_valid, fast_conv_valid} = 3'b000;
    hit[t] = 2'b00;
    fin[t] = 1'b1;
    @(negedge clk);
    fin[t] = 1'b0;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    reset = 1'b1;
    {clr_en, clr_addr, go, fin, sv, vds_conv_valid, fast_conv_valid} = '0;
    {watchdog_timeout, hardware_lockout, stop_unneeded} = 3'b000;
    {vds_conv_data, fast_conv_data} = '0;
    hit = '{default: 2'b00};
    smp = '{default: 10'h000};
    lfsr = 16'h3603;
    num_errors = 0;
    num_checks = 0;
    repeat (20) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    for (int a = 'h14; a < 'h1A; a++) begin
      rd(a[5:0], (a > 'h14 && a < 'h19) ? word(23'h000000) : WORD_RESET);
    end
    $display("test idle words done");
    f = rnd();
    conv(1'b1, f);
    rd(FAST_CURRENT_OFFSET, word({12'h000, f, 1'b1}));
    rd(FAST_CURRENT_OFFSET, word({12'h000, f, 1'b0}));
    $display("test fast sample done");
    for (int i = 0; i < 4; i++) begin
      l = (i == 0) ? 10'h3FF : rnd();
      s = (i == 0) ? 10'h000 : rnd();
      conv(1'b0, l);
      run_t(0, s, i[1:0]);
      check("live value", {14'h0000, vds_live_value}, {14'h0000, l});
      rd(VDS_RESULT_OFFSET, word({10'h000, i[0], s - l, TEST_END}));
    end
    clear(VDS_RESULT_OFFSET);
    rd(VDS_RESULT_OFFSET, word(23'h000000));
    $display("test drain source done");
    s = rnd();
    run_t(1, s, 2'b01);
    rd(STUCKON_RESULT_OFFSET, word({9'h000, 2'b11, s, TEST_END}));
    rd(STUCKON_RESULT_OFFSET, word({9'h000, 2'b01, s, TEST_END}));
    s = rnd();
    @(negedge clk);
    go[1] = 1'b1;
    @(negedge clk);
    {go[1], fin[1]} = 2'b01;
    @(negedge clk);
    fin[1] = 1'b0;
    rd(STUCKON_RESULT_OFFSET, {21'h000000, TEST_RUN, 1'b0}, 24'h000006);
    sv[1] = 1'b1;
    smp[1] = s;
    @(negedge clk);
    sv[1] = 1'b0;
    rd(STUCKON_RESULT_OFFSET, word({9'h000, 2'b10, s, TEST_END}));
    $display("test stuck on done");
    for (int i = 1; i < 4; i++) begin
      f = rnd();
      s = rnd();
      conv(1'b1, f);
      run_t(2, s, i[1:0]);
      rd(CURRENT_RESULT_OFFSET, word({9'h000, i[1:0], s - f, TEST_END}));
      rd(FAST_CURRENT_OFFSET, word({12'h000, f, 1'b1}));
    end
    $display("test current sense done");
    for (int k = 0; k < 3; k++) begin
      @(negedge clk);
      go[1] = 1'b1;
      @(negedge clk);
      go[1] = 1'b0;
      {stop_unneeded, hardware_lockout, watchdog_timeout} = 3'b001 << k;
      @(negedge clk);
      {stop_unneeded, hardware_lockout, watchdog_timeout} = 3'b000;
      rd(STUCKON_RESULT_OFFSET, {21'h000000, TEST_ABORT, 1'b0}, 24'h000006);
      clear(STUCKON_RESULT_OFFSET);
      rd(STUCKON_RESULT_OFFSET, word(23'h000000));
    end
    $display("test abort done");
    end_of_test();
  end
endmodule // testbench
`default_nettype wire
